// *** test_usb_status_fifo_and_control.sv ***
// Self-checking bench for the USB status queue and control block.
// Assumes the engine model is compiled first; registers are reached over Wishbone.
`timescale 1ns/1ps
module test_usb_status_fifo_and_control;
	localparam int SOF_N = 20;
	localparam int RES_N = 25;
	logic        clk = 1'h0, rst_n = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'hf;
	logic [31:0] wdat = 32'h0, rdat;
	logic        ack, j, se0, done, tx, odd, setup, tstart, tend, flag, full, pkt_off, busy;
	logic        brst, host, hrst, resume, eop, ppb, men, sof, lsp;
	logic [3:0]  ep;
	logic [6:0]  fadr;
	logic [5:0]  ent [4] = '{6'h3f, 6'h00, 6'h2a, 6'h15};
	int          num_errors = 0, checks = 0, hrst_cnt = 0, eop_cnt = 0, sof_cnt = 0, e0;
	time         sof_last = 0, sof_prev = 0;

	initial begin
		forever #(usbsc_pkg::CLK_PERIOD_NS / 2) clk = ~clk;
	end

	usbsc_core #(.FIFO_DEPTH(4), .SOF_CYCLES(SOF_N)) usbsc_core_inst (
		.core_clk_i(clk), .rst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.live_j_level_i(j), .live_se0_i(se0), .trans_done_i(done), .trans_endpoint_i(ep),
		.trans_tx_i(tx), .trans_odd_i(odd), .setup_token_i(setup), .token_start_i(tstart),
		.token_end_i(tend), .transaction_done_flag_o(flag), .status_queue_full_o(full),
		.packet_processing_off_o(pkt_off), .token_in_progress_o(busy),
		.bus_reset_drive_o(brst), .host_role_enable_o(host), .host_logic_reset_o(hrst),
		.resume_drive_o(resume), .resume_eop_o(eop), .pingpong_pointer_clear_o(ppb),
		.module_enable_o(men), .sof_send_o(sof), .low_speed_next_token_o(lsp),
		.function_address_o(fadr));

	usbsc_engine_model usbsc_engine_model_inst (
		.core_clk_i(clk), .full_i(full), .j_o(j), .se0_o(se0), .done_o(done), .ep_o(ep),
		.tx_o(tx), .odd_o(odd), .setup_o(setup), .tok_start_o(tstart), .tok_end_o(tend));

	always @(posedge clk) begin
		hrst_cnt <= hrst_cnt + int'(hrst === 1'h1);
		eop_cnt <= eop_cnt + int'(eop === 1'h1);
		if (sof === 1'h1) begin
			sof_cnt <= sof_cnt + 1;
			sof_last <= $time;
			sof_prev <= sof_last;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q);
		@(posedge clk);
		{cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
		@(posedge clk);
		// Only the watchdog ends a wait for an acknowledge that never comes.
		while (ack !== 1'h1) @(posedge clk);
		q = rdat;
		{cyc, stb, we} <= 3'h0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'h1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'h0, a, 32'h0, q);
		chk(q, exp);
	endtask

	task automatic give_verdict;
		if (num_errors == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		#(20000 * usbsc_pkg::CLK_PERIOD_NS);
		chk(32'h0, 32'h1);
		give_verdict();
	end

	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		chk({flag, full, pkt_off, busy, brst, host, resume, eop, ppb, men, lsp, fadr}, 32'h0);
		rd(usbsc_pkg::OFF_CONTROL, 32'h0);
		rd(8'h10, 32'h0);
		wr(usbsc_pkg::OFF_ADDRESS, 32'hffff_ffff);
		rd(usbsc_pkg::OFF_ADDRESS, 32'h0000_00ff);
		chk({lsp, fadr}, 32'hff);
		wr(usbsc_pkg::OFF_ADDRESS, 32'h05);
		chk({lsp, fadr}, 32'h05);
		sel <= 4'he;
		wr(usbsc_pkg::OFF_ADDRESS, 32'h7f);
		sel <= 4'hf;
		rd(usbsc_pkg::OFF_ADDRESS, 32'h05);
		for (int i = 0; i < 4; i++) begin
			usbsc_engine_model_inst.complete(ent[i][5:2], ent[i][1], ent[i][0]);
		end
		@(posedge clk);
		chk(full, 32'h1);
		for (int i = 0; i < 4; i++) begin
			rd(usbsc_pkg::OFF_IRQFLAG, 32'h08);
			rd(usbsc_pkg::OFF_STATUS, {24'h0, ent[i], 2'h0});
			wr(usbsc_pkg::OFF_IRQFLAG, 32'h08);
		end
		chk(flag, 32'h0);
		usbsc_engine_model_inst.line(1'h1, 1'h0);
		rd(usbsc_pkg::OFF_CONTROL, 32'h80);
		usbsc_engine_model_inst.line(1'h0, 1'h1);
		rd(usbsc_pkg::OFF_CONTROL, 32'h40);
		usbsc_engine_model_inst.line(1'h0, 1'h0);
		wr(usbsc_pkg::OFF_CONTROL, 32'h23);
		chk({pkt_off, ppb, men}, 32'h7);
		wr(usbsc_pkg::OFF_CONTROL, 32'h01);
		usbsc_engine_model_inst.strobe(0);
		rd(usbsc_pkg::OFF_CONTROL, 32'h21);
		wr(usbsc_pkg::OFF_CONTROL, 32'h10);
		chk({brst, men, ppb}, 32'h4);
		wr(usbsc_pkg::OFF_CONTROL, 32'h08);
		chk({brst, host, men}, 32'h2);
		usbsc_engine_model_inst.strobe(1);
		@(posedge clk);
		chk(busy, 32'h1);
		rd(usbsc_pkg::OFF_CONTROL, 32'h28);
		usbsc_engine_model_inst.strobe(2);
		rd(usbsc_pkg::OFF_CONTROL, 32'h08);
		wr(usbsc_pkg::OFF_CONTROL, 32'h0c);
		chk({resume, eop}, 32'h2);
		// Resume is held a scaled span; the real hold would not fit the cycle budget.
		repeat (RES_N) @(posedge clk);
		e0 = eop_cnt;
		wr(usbsc_pkg::OFF_CONTROL, 32'h08);
		repeat (40) @(posedge clk);
		chk(32'(eop_cnt - e0), 32'(usbsc_pkg::LS_EOP_CYCLES));
		wr(usbsc_pkg::OFF_CONTROL, 32'h09);
		repeat (3 * SOF_N) @(posedge clk);
		chk(32'(sof_last - sof_prev), 32'(SOF_N * usbsc_pkg::CLK_PERIOD_NS));
		wr(usbsc_pkg::OFF_CONTROL, 32'h08);
		repeat (2) @(posedge clk);
		e0 = sof_cnt;
		repeat (2 * SOF_N) @(posedge clk);
		chk(32'(sof_cnt - e0), 32'h0);
		wr(usbsc_pkg::OFF_CONTROL, 32'h00);
		repeat (3) @(posedge clk);
		chk(32'(hrst_cnt), 32'h2);
		give_verdict();
	end
endmodule

// *** usbsc_core.sv ***
// Status queue and control registers of a full-speed USB OTG module.
// Assumes synchronous USB engine strobes and a classic Wishbone master.
//
// Function
// - Status bits 7:4 give last endpoint.
// - Status bit 3 set for transmit.
// - Status bit 2 set for odd bank.
// - Status register is head of queue.
// - Status valid only while done flag set.
// - Clearing done flag pops the queue.
// - Control bit 7 shows live J state.
// - Control bit 6 shows live SE0.
// - Device mode: bit 5 disables packets, SETUP sets.
// - Host mode: bit 5 shows token busy.
// - Control bit 4 drives bus reset.
// - Host enable toggle resets host logic.
// - Host clearing resume appends low-speed EOP.
// - Bit 1 forces pointers to even bank.
// - Device mode: bit 0 enables module.
// - Host mode: bit 0 sends SOF per 1 ms.
// - Bits 31:8 read zero, ignore writes.
// - Address bit 7 selects low speed.
// - Address bits 6:0 hold device address.
`timescale 1ns/1ps

module usbsc_core #(
	parameter int FIFO_DEPTH = 4,
	parameter int SOF_CYCLES = usbsc_pkg::SOF_CYCLES_DEF
) (
	input  wire logic        core_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        live_j_level_i,
	input  wire logic        live_se0_i,
	input  wire logic        trans_done_i,
	input  wire logic [3:0]  trans_endpoint_i,
	input  wire logic        trans_tx_i,
	input  wire logic        trans_odd_i,
	input  wire logic        setup_token_i,
	input  wire logic        token_start_i,
	input  wire logic        token_end_i,
	output logic             transaction_done_flag_o,
	output logic             status_queue_full_o,
	output logic             packet_processing_off_o,
	output logic             token_in_progress_o,
	output logic             bus_reset_drive_o,
	output logic             host_role_enable_o,
	output logic             host_logic_reset_o,
	output logic             resume_drive_o,
	output logic             resume_eop_o,
	output logic             pingpong_pointer_clear_o,
	output logic             module_enable_o,
	output logic             sof_send_o,
	output logic             low_speed_next_token_o,
	output logic [6:0]       function_address_o
);

	localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
	localparam int CW = $clog2(FIFO_DEPTH + 1);
	localparam int SW = $clog2(SOF_CYCLES + 1);
	localparam int EW = $clog2(usbsc_pkg::LS_EOP_CYCLES + 1);

	typedef struct packed {
		logic                        ack;
		logic [31:0]                 dat;
		logic [FIFO_DEPTH-1:0][5:0]  q;
		logic [PW-1:0]               rd_ptr;
		logic [PW-1:0]               wr_ptr;
		logic [CW-1:0]               count;
		logic                        flag;
		logic                        full;
		logic [5:0]                  con;
		logic                        j_level;
		logic                        se0;
		logic                        tok_busy;
		logic                        host_rst;
		logic [EW-1:0]               eop_cnt;
		logic                        eop;
		logic [SW-1:0]               sof_cnt;
		logic                        sof;
		logic [7:0]                  addr;
		logic                        pkt_off;
		logic                        men;
	} usbsc_state_t;

	usbsc_state_t s_r;
	usbsc_state_t s_nxt;

	function automatic logic usbsc_hit(input logic [7:0] adr, input logic [7:0] off);
		usbsc_hit = (adr == off);
	endfunction

	function automatic logic [7:0] usbsc_con_view(input usbsc_state_t s);
		logic mid;
		mid = s.con[usbsc_pkg::CON_HOST_BIT] ? s.tok_busy : s.con[usbsc_pkg::CON_PKT_BIT];
		usbsc_con_view = {s.j_level, s.se0, mid, s.con[4:0]};
	endfunction

	logic       req_new;
	logic       wr;
	logic       pop;
	logic       push;
	logic       host_on;
	logic [5:0] head;
	logic [5:0] con_w;

	always_comb begin
		s_nxt = s_r;
		req_new = wb_cyc_i & wb_stb_i & ~s_r.ack;
		wr = req_new & wb_we_i & wb_sel_i[0];
		host_on = s_r.con[usbsc_pkg::CON_HOST_BIT];
		head = s_r.q[s_r.rd_ptr];
		con_w = wb_dat_i[5:0];
		s_nxt.ack = req_new;
		s_nxt.host_rst = 1'b0;
		s_nxt.sof = 1'b0;
		s_nxt.j_level = live_j_level_i;
		s_nxt.se0 = live_se0_i;

		// Read data is latched with the ack; only byte 0 exists.
		if (req_new) begin
			s_nxt.dat = 32'h0000_0000;
			if (usbsc_hit(wb_adr_i, usbsc_pkg::OFF_STATUS)) begin
				s_nxt.dat[7:0] = {head, 2'b00};
			end else if (usbsc_hit(wb_adr_i, usbsc_pkg::OFF_CONTROL)) begin
				s_nxt.dat[7:0] = usbsc_con_view(s_r);
			end else if (usbsc_hit(wb_adr_i, usbsc_pkg::OFF_ADDRESS)) begin
				s_nxt.dat[7:0] = s_r.addr;
			end else if (usbsc_hit(wb_adr_i, usbsc_pkg::OFF_IRQFLAG)) begin
				s_nxt.dat[usbsc_pkg::IRQ_DONE_BIT] = s_r.flag;
			end
		end

		// Status queue: a completion is only accepted while there is room.
		pop = wr & usbsc_hit(wb_adr_i, usbsc_pkg::OFF_IRQFLAG)
			& wb_dat_i[usbsc_pkg::IRQ_DONE_BIT] & (s_r.count != '0);
		push = trans_done_i & (s_r.count != CW'(FIFO_DEPTH));
		if (push) begin
			s_nxt.q[s_r.wr_ptr] = {trans_endpoint_i, trans_tx_i, trans_odd_i};
			s_nxt.wr_ptr = PW'(s_r.wr_ptr + 1'b1);
		end
		if (pop) begin
			s_nxt.rd_ptr = PW'(s_r.rd_ptr + 1'b1);
		end
		if (push & ~pop) begin
			s_nxt.count = CW'(s_r.count + 1'b1);
		end else if (pop & ~push) begin
			s_nxt.count = CW'(s_r.count - 1'b1);
		end
		// A push in the clearing cycle keeps the flag up.
		s_nxt.flag = (s_nxt.count != '0);
		s_nxt.full = (s_nxt.count == CW'(FIFO_DEPTH));

		// Control register writes.
		if (wr & usbsc_hit(wb_adr_i, usbsc_pkg::OFF_CONTROL)) begin
			s_nxt.con = con_w;
			if (host_on) begin
				s_nxt.con[usbsc_pkg::CON_PKT_BIT] = s_r.con[usbsc_pkg::CON_PKT_BIT];
			end
		end
		if (setup_token_i & ~host_on) begin
			s_nxt.con[usbsc_pkg::CON_PKT_BIT] = 1'b1;
		end
		if (wr & usbsc_hit(wb_adr_i, usbsc_pkg::OFF_ADDRESS)) begin
			s_nxt.addr = wb_dat_i[7:0];
		end

		// Token busy in host mode.
		if (host_on & token_start_i) begin
			s_nxt.tok_busy = 1'b1;
		end else if (token_end_i | ~host_on) begin
			s_nxt.tok_busy = 1'b0;
		end

		// Low-speed EOP after resume is released by a host.
		if (host_on & s_r.con[usbsc_pkg::CON_RES_BIT] & ~s_nxt.con[usbsc_pkg::CON_RES_BIT]) begin
			s_nxt.eop_cnt = EW'(usbsc_pkg::LS_EOP_CYCLES);
		end else if (s_r.eop_cnt != '0) begin
			s_nxt.eop_cnt = EW'(s_r.eop_cnt - 1'b1);
		end
		s_nxt.eop = (s_nxt.eop_cnt != '0);

		// Start-of-frame timer in host mode.
		if (host_on & s_r.con[usbsc_pkg::CON_EN_BIT]) begin
			if (s_r.sof_cnt == SW'(SOF_CYCLES - 1)) begin
				s_nxt.sof_cnt = '0;
				s_nxt.sof = 1'b1;
			end else begin
				s_nxt.sof_cnt = SW'(s_r.sof_cnt + 1'b1);
			end
		end else begin
			s_nxt.sof_cnt = '0;
		end

		// Any change of the host enable restarts all host-side state.
		if (s_nxt.con[usbsc_pkg::CON_HOST_BIT] != host_on) begin
			s_nxt.host_rst = 1'b1;
			s_nxt.tok_busy = 1'b0;
			s_nxt.sof_cnt = '0;
			s_nxt.sof = 1'b0;
			s_nxt.eop_cnt = '0;
			s_nxt.eop = 1'b0;
		end

		// Gated outputs get flops of their own, so no logic follows the state.
		s_nxt.pkt_off = s_nxt.con[usbsc_pkg::CON_PKT_BIT] & ~s_nxt.con[usbsc_pkg::CON_HOST_BIT];
		s_nxt.men = s_nxt.con[usbsc_pkg::CON_EN_BIT] & ~s_nxt.con[usbsc_pkg::CON_HOST_BIT];
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			s_r <= '0;
			s_r.con <= usbsc_pkg::CON_RESET;
			s_r.addr <= usbsc_pkg::ADDR_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign wb_dat_o = s_r.dat;
	assign wb_ack_o = s_r.ack;
	assign transaction_done_flag_o = s_r.flag;
	assign status_queue_full_o = s_r.full;
	assign packet_processing_off_o = s_r.pkt_off;
	assign token_in_progress_o = s_r.tok_busy;
	assign bus_reset_drive_o = s_r.con[usbsc_pkg::CON_RST_BIT];
	assign host_role_enable_o = s_r.con[usbsc_pkg::CON_HOST_BIT];
	assign host_logic_reset_o = s_r.host_rst;
	assign resume_drive_o = s_r.con[usbsc_pkg::CON_RES_BIT];
	assign resume_eop_o = s_r.eop;
	assign pingpong_pointer_clear_o = s_r.con[usbsc_pkg::CON_PPB_BIT];
	assign module_enable_o = s_r.men;
	assign sof_send_o = s_r.sof;
	assign low_speed_next_token_o = s_r.addr[usbsc_pkg::ADR_LS_BIT];
	assign function_address_o = s_r.addr[6:0];

	// Checks.
	ack_single_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");

	upper_zero_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000) else $error("upper read bits not zero");

	status_entry_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(s_r.count == '0 && trans_done_i) ##1 (wb_cyc_i && wb_stb_i && !wb_we_i
		&& !s_r.ack && wb_adr_i == usbsc_pkg::OFF_STATUS && !pop)
		|=> wb_dat_o[7:2] == {$past(trans_endpoint_i, 2), $past(trans_tx_i, 2),
		$past(trans_odd_i, 2)}) else $error("status head differs from completion");

	flag_raise_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(s_r.count == '0 && trans_done_i) |=> transaction_done_flag_o)
		else $error("done flag not raised");

	pop_last_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(pop && s_r.count == CW'(1) && !trans_done_i) |=> !transaction_done_flag_o)
		else $error("flag stayed after last entry popped");

	full_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(status_queue_full_o && !pop) |=> s_r.count == CW'(FIFO_DEPTH))
		else $error("full queue changed without pop");

	setup_off_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(setup_token_i && !host_role_enable_o) |=> s_r.con[usbsc_pkg::CON_PKT_BIT])
		else $error("SETUP did not disable packets");

	busy_track_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(host_role_enable_o && token_start_i && !wb_cyc_i) |=> token_in_progress_o)
		else $error("token busy not set");

	host_toggle_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		$changed(host_role_enable_o) |-> host_logic_reset_o && !token_in_progress_o)
		else $error("host toggle did not reset host logic");

	eop_tail_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		($fell(resume_drive_o) && host_role_enable_o && !host_logic_reset_o)
		|-> resume_eop_o [*2]) else $error("low-speed EOP not appended");

	sof_gate_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		sof_send_o |-> $past(host_role_enable_o) && $past(s_r.con[usbsc_pkg::CON_EN_BIT]))
		else $error("SOF sent while disabled");

	// Register side effects show one cycle after the edge that takes the request.
	// The queue head is checked inside when a completion enters an empty queue, so a wrong first entry is caught before software reads it.
	head_entry_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(s_r.count == '0 && trans_done_i) |=> head == {$past(trans_endpoint_i),
		$past(trans_tx_i), $past(trans_odd_i)}) else $error("queued entry differs from completion");

	status_read_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(req_new && !wb_we_i && wb_adr_i == usbsc_pkg::OFF_STATUS)
		|=> wb_dat_o[7:0] == {$past(head), 2'b00}) else $error("status read is not queue head");

	count_bound_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		s_r.count <= CW'(FIFO_DEPTH))
		else $error("queue count beyond depth");

	flag_read_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(req_new && !wb_we_i && wb_adr_i == usbsc_pkg::OFF_IRQFLAG)
		|=> wb_dat_o[usbsc_pkg::IRQ_DONE_BIT] == $past(transaction_done_flag_o))
		else $error("flag read differs from done flag");

	flag_full_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		status_queue_full_o |-> transaction_done_flag_o)
		else $error("full queue without done flag");

	pop_advance_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		pop |=> s_r.rd_ptr == PW'($past(s_r.rd_ptr) + 1'b1))
		else $error("pop did not advance the queue");

	live_j_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		1'b1 |=> s_r.j_level == $past(live_j_level_i))
		else $error("J level not tracked");

	live_se0_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		1'b1 |=> s_r.se0 == $past(live_se0_i))
		else $error("SE0 level not tracked");

	pkt_write_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(wr && wb_adr_i == usbsc_pkg::OFF_CONTROL && !host_on && !setup_token_i)
		|=> s_r.con[usbsc_pkg::CON_PKT_BIT] == $past(wb_dat_i[usbsc_pkg::CON_PKT_BIT]))
		else $error("packet disable write lost");

	pkt_host_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(wr && wb_adr_i == usbsc_pkg::OFF_CONTROL && host_on)
		|=> s_r.con[usbsc_pkg::CON_PKT_BIT] == $past(s_r.con[usbsc_pkg::CON_PKT_BIT]))
		else $error("busy bit written in host mode");

	busy_view_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(req_new && !wb_we_i && wb_adr_i == usbsc_pkg::OFF_CONTROL && host_on)
		|=> wb_dat_o[usbsc_pkg::CON_PKT_BIT] == $past(token_in_progress_o))
		else $error("control read does not show token busy");

	busy_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(token_end_i && !token_start_i) |=> !token_in_progress_o)
		else $error("token busy not cleared");

	busy_device_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		!host_role_enable_o |-> !token_in_progress_o)
		else $error("token busy outside host mode");

	reset_write_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(wr && wb_adr_i == usbsc_pkg::OFF_CONTROL)
		|=> bus_reset_drive_o == $past(wb_dat_i[usbsc_pkg::CON_RST_BIT]))
		else $error("bus reset drive not written");

	pingpong_write_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(wr && wb_adr_i == usbsc_pkg::OFF_CONTROL)
		|=> pingpong_pointer_clear_o == $past(wb_dat_i[usbsc_pkg::CON_PPB_BIT]))
		else $error("pointer clear not written");

	enable_write_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(wr && wb_adr_i == usbsc_pkg::OFF_CONTROL && !wb_dat_i[usbsc_pkg::CON_HOST_BIT])
		|=> module_enable_o == $past(wb_dat_i[usbsc_pkg::CON_EN_BIT]))
		else $error("module enable not written");

	eop_load_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		$rose(resume_eop_o) |-> s_r.eop_cnt == EW'(usbsc_pkg::LS_EOP_CYCLES))
		else $error("EOP length not loaded");

	sof_gap_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		sof_send_o |=> !sof_send_o)
		else $error("SOF pulses back to back");

	addr_write_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(wr && wb_adr_i == usbsc_pkg::OFF_ADDRESS)
		|=> {low_speed_next_token_o, function_address_o} == $past(wb_dat_i[7:0]))
		else $error("address register not written");

	sof_cover_c: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) sof_send_o);
	full_cover_c: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) status_queue_full_o);
	pop_cover_c: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) pop && push);
	eop_cover_c: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) $rose(resume_eop_o));
	busy_cover_c: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) token_in_progress_o);

endmodule

// *** usbsc_engine_model.sv ***
// Behavioural USB engine beside the status queue: line levels and event strobes.
// Assumes the bench calls its tasks; every strobe changes just after a rising edge.
`timescale 1ns/1ps
module usbsc_engine_model (
	input  wire logic core_clk_i,
	input  wire logic full_i,
	output logic       j_o,
	output logic       se0_o,
	output logic       done_o,
	output logic [3:0] ep_o,
	output logic       tx_o,
	output logic       odd_o,
	output logic       setup_o,
	output logic       tok_start_o,
	output logic       tok_end_o
);
	initial begin
		{j_o, se0_o, done_o, ep_o, tx_o, odd_o, setup_o, tok_start_o, tok_end_o} = '0;
	end
	// Fields are inverted once the pulse is over, so a stale sample never matches.
	task automatic complete(input logic [3:0] ep, input logic tx, input logic odd);
		@(posedge core_clk_i);
		while (full_i) @(posedge core_clk_i);
		done_o <= 1'h1;
		{ep_o, tx_o, odd_o} <= {ep, tx, odd};
		@(posedge core_clk_i);
		done_o <= 1'h0;
		{ep_o, tx_o, odd_o} <= ~{ep, tx, odd};
	endtask
	task automatic strobe(input int which);
		@(posedge core_clk_i);
		{setup_o, tok_start_o, tok_end_o} <= 3'(3'h4 >> which);
		@(posedge core_clk_i);
		{setup_o, tok_start_o, tok_end_o} <= 3'h0;
	endtask
	task automatic line(input logic j, input logic se0);
		@(posedge core_clk_i);
		{j_o, se0_o} <= {j, se0};
	endtask
endmodule

// *** usbsc_pkg.sv ***
// Constants shared by the USB status queue and control block.
// Assumes a 20 MHz system clock and a 32-bit classic Wishbone register bus.
package usbsc_pkg;

	localparam int CLK_PERIOD_PS = 50000;
	localparam int CLK_PERIOD_NS = 50;

	// Byte addresses of the registers.
	localparam logic [7:0] OFF_STATUS  = 8'h00;
	localparam logic [7:0] OFF_CONTROL = 8'h04;
	localparam logic [7:0] OFF_ADDRESS = 8'h08;
	localparam logic [7:0] OFF_IRQFLAG = 8'h0c;

	// Transaction status fields.
	localparam int ST_EP_LSB   = 4;
	localparam int ST_DIR_BIT  = 3;
	localparam int ST_ODD_BIT  = 2;

	// Module control fields.
	localparam int CON_J_BIT    = 7;
	localparam int CON_SE0_BIT  = 6;
	localparam int CON_PKT_BIT  = 5;
	localparam int CON_RST_BIT  = 4;
	localparam int CON_HOST_BIT = 3;
	localparam int CON_RES_BIT  = 2;
	localparam int CON_PPB_BIT  = 1;
	localparam int CON_EN_BIT   = 0;

	// Address register fields.
	localparam int ADR_LS_BIT = 7;

	// Interrupt flag register: transaction done, write one to clear.
	localparam int IRQ_DONE_BIT = 3;

	// Reset values.
	localparam logic [5:0] CON_RESET  = 6'h00;
	localparam logic [7:0] ADDR_RESET = 8'h00;

	// Start-of-frame period in host mode.
	localparam int SOF_PERIOD_NS  = 1000000;
	localparam int SOF_CYCLES_DEF = SOF_PERIOD_NS / CLK_PERIOD_NS;

	// Low-speed end of packet appended to resume, two low-speed bit times.
	localparam int LS_EOP_NS     = 1334;
	localparam int LS_EOP_CYCLES = (LS_EOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage
